// >>> src/sdac_pkg.sv
// Package for the security debug authentication control register bank
package sdac_pkg;

   // ---------------------------------------------------------------
   // Bus widths and register offsets within the 4KB region
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam logic [11:0] OFS_IC_STAT   = 12'h000;
   localparam logic [11:0] OFS_IC_SET    = 12'h004;
   localparam logic [11:0] OFS_IC_CLR    = 12'h008;
   localparam logic [11:0] OFS_DBG_STAT  = 12'h010;
   localparam logic [11:0] OFS_DBG_SET   = 12'h014;
   localparam logic [11:0] OFS_DBG_CLR   = 12'h018;
   localparam logic [11:0] OFS_AUX_DBG   = 12'h01c;
   localparam logic [11:0] OFS_WDOG_HOD  = 12'h024;
   localparam logic [11:0] OFS_GP_STORE  = 12'h030;
   localparam logic [11:0] OFS_VERSION   = 12'h040;
   localparam logic [11:0] OFS_PERIPH_4  = 12'hfd0;
   localparam logic [11:0] OFS_PERIPH_0  = 12'hfe0;
   localparam logic [11:0] OFS_PERIPH_1  = 12'hfe4;
   localparam logic [11:0] OFS_PERIPH_2  = 12'hfe8;
   localparam logic [11:0] OFS_PERIPH_3  = 12'hfec;
   localparam logic [11:0] OFS_COMP_0    = 12'hff0;
   localparam logic [11:0] OFS_COMP_1    = 12'hff4;
   localparam logic [11:0] OFS_COMP_2    = 12'hff8;
   localparam logic [11:0] OFS_COMP_3    = 12'hffc;

   // ---------------------------------------------------------------
   // Field layout: debug status holds bits 7..2, lowest at bit 2
   // ---------------------------------------------------------------
   localparam int          DBG_LSB       = 2;
   localparam int          DBG_W         = 6;
   localparam int          AUX_W         = 2;
   localparam int          WDOG_W        = 2;
   localparam int          GP_W          = 16;
   // Index into the 6-bit debug field, then into the 2-bit watchdog field
   localparam int          IX_SIV_SEL    = 5;
   localparam int          IX_SIV_INT    = 4;
   localparam int          IX_SNI_SEL    = 3;
   localparam int          IX_SNI_INT    = 2;
   localparam int          IX_DEV_SEL    = 1;
   localparam int          IX_DEV_INT    = 0;
   localparam int          IX_CPU_WDOG   = 1;
   localparam int          IX_TRUST_WDOG = 0;

   // ---------------------------------------------------------------
   // Reset values, auxiliary override codes and constant read values
   // ---------------------------------------------------------------
   localparam logic [5:0]  DBG_RST       = 6'h00;
   localparam logic [1:0]  AUX_RST       = 2'h0;
   localparam logic [1:0]  WDOG_RST      = 2'h0;
   localparam logic [15:0] GP_RST        = 16'h0000;
   localparam logic [1:0]  AUX_ALL_EN    = 2'h0;
   localparam logic [1:0]  AUX_NONINV    = 2'h1;
   localparam logic [31:0] PERIPH_3_VAL  = 32'h0000_0000;
   localparam logic [31:0] COMP_0_VAL    = 32'h0000_000d;
   localparam logic [31:0] COMP_1_VAL    = 32'h0000_00f0;
   localparam logic [31:0] COMP_2_VAL    = 32'h0000_0005;
   localparam logic [31:0] COMP_3_VAL    = 32'h0000_00b1;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Bus carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              nonsecure;
      logic [11:0]       addr;
      logic [31:0]       wdata;
   } sdac_req_t;

   typedef struct packed {
      logic              valid;
      logic              decerr;
      logic [31:0]       rdata;
   } sdac_rsp_t;

   // Debug enables leaving the block
   typedef struct packed {
      logic              sec_inv;
      logic              sec_noninv;
      logic              device;
      logic              inv;
      logic              noninv;
   } sdac_dbg_en_t;

   // Whole state of the bank
   typedef struct packed {
      logic [5:0]        dbg;
      logic [1:0]        aux;
      logic [1:0]        wdog;
      logic [15:0]       gp;
      sdac_rsp_t         rsp;
      sdac_dbg_en_t      en;
   } sdac_state_t;

endpackage

// >>> src/sdac_bank.sv
// Security debug authentication control register bank, top module
//
// Contract
// - Non-secure accesses get a decode error answer.
// - Secure accesses to unimplemented locations read zero, writes dropped.
// - All contents live in the always-on domain; only supply loss clears.
// - Interconnect status, set and clear words always read zero.
// - Bit 7 picks external input or bit 6 for secure invasive enable.
// - Bit 5 picks external input or bit 4 for secure non-invasive enable.
// - Bit 3 picks external input or bit 2 for device enable.
// - Debug status is read-only at 0x010, resets zero, unused bits zero.
// - Ones written to set alias bits 7..2 set status; alias reads zero.
// - Ones written to clear alias bits 7..2 clear status; reads zero.
// - Auxiliary debug configuration word is read-write at 0x01C.
// - Watchdog halt-on-debug word is read-write at 0x024, resets zero.
// - General secure storage word is read-write at 0x030, resets zero.
// - Version word at 0x040 is read-only and returns a fixed value.
// - Peripheral identity words at 0xFD0, 0xFE0..0xFEC; 0xFEC reads zero.
// - Component identity words read 0x0D, 0xF0, 0x05 and 0xB1.
// - Aux bits 1..0: 00 all on, 01 invasive off only, 1x both off.
// - Watchdog bit 1 drives control-cpu halt, bit 0 trusted halt.
// - Storage keeps 16 bits, upper reads zero, power-up reset only.
`timescale 1ns/100ps

module sdac_bank
   import sdac_pkg::*;
#(
   parameter logic [31:0] VERSION_VAL  = 32'h0000_0001, // Arbitrary value
   parameter logic [31:0] PERIPH_4_VAL = 32'h0000_0002, // Arbitrary value
   parameter logic [31:0] PERIPH_0_VAL = 32'h0000_0003, // Arbitrary value
   parameter logic [31:0] PERIPH_1_VAL = 32'h0000_0006, // Arbitrary value
   parameter logic [31:0] PERIPH_2_VAL = 32'h0000_0007  // Arbitrary value
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    resetn_in,
   input  wire sdac_pkg::sdac_req_t     bus_req_in,
   output      sdac_pkg::sdac_rsp_t     bus_rsp_out,
   input  wire logic                    secure_invasive_cfg_input_in,
   input  wire logic                    secure_noninvasive_cfg_input_in,
   input  wire logic                    device_dbg_cfg_input_in,
   output      logic                    secure_invasive_dbg_en_out,
   output      logic                    secure_noninvasive_dbg_en_out,
   output      logic                    device_dbg_en_out,
   output      logic                    invasive_dbg_en_out,
   output      logic                    noninvasive_dbg_en_out,
   output      logic                    control_cpu_wdog_halt_enable_out,
   output      logic                    trusted_wdog_halt_enable_out
);
   import sdac_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   sdac_state_t st_r;
   sdac_state_t st_nxt;
   logic [11:0] word_addr;
   logic        sec_ok;
   logic        wr_ok;
   logic [5:0]  dbg_wbits;

   // Offsets are word addressed; the byte lane bits are ignored
   assign word_addr = {bus_req_in.addr[11:2], 2'b00};
   // Non-secure requests never reach the register state
   assign sec_ok    = bus_req_in.valid && !bus_req_in.nonsecure;
   assign wr_ok     = sec_ok && bus_req_in.write;
   // Only bits 7..2 of an alias write matter; reserved bits fall away
   assign dbg_wbits = bus_req_in.wdata[DBG_LSB +: DBG_W];

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [11:0] a,
                                             input sdac_state_t  s);
      logic [31:0] v;
      v = ZERO_WORD;
      case (a)
         // Interconnect words and write aliases have no readable fields
         OFS_IC_STAT,
         OFS_IC_SET,
         OFS_IC_CLR,
         OFS_DBG_SET,
         OFS_DBG_CLR:  v = ZERO_WORD;
         OFS_DBG_STAT: v[DBG_LSB +: DBG_W] = s.dbg;
         OFS_AUX_DBG:  v[AUX_W-1:0] = s.aux;
         OFS_WDOG_HOD: v[WDOG_W-1:0] = s.wdog;
         OFS_GP_STORE: v[GP_W-1:0] = s.gp;
         OFS_VERSION:  v = VERSION_VAL;
         OFS_PERIPH_4: v = PERIPH_4_VAL;
         OFS_PERIPH_0: v = PERIPH_0_VAL;
         OFS_PERIPH_1: v = PERIPH_1_VAL;
         OFS_PERIPH_2: v = PERIPH_2_VAL;
         OFS_PERIPH_3: v = PERIPH_3_VAL;
         OFS_COMP_0:   v = COMP_0_VAL;
         OFS_COMP_1:   v = COMP_1_VAL;
         OFS_COMP_2:   v = COMP_2_VAL;
         OFS_COMP_3:   v = COMP_3_VAL;
         default:      v = ZERO_WORD;
      endcase
      return v;
   endfunction

   // True for every listed offset; any other word in the region is a hole
   function automatic logic is_mapped(input logic [11:0] a);
      logic m;
      m = 1'b0;
      case (a)
         OFS_IC_STAT,  OFS_IC_SET,   OFS_IC_CLR,   OFS_DBG_STAT,
         OFS_DBG_SET,  OFS_DBG_CLR,  OFS_AUX_DBG,  OFS_WDOG_HOD,
         OFS_GP_STORE, OFS_VERSION,  OFS_PERIPH_4, OFS_PERIPH_0,
         OFS_PERIPH_1, OFS_PERIPH_2, OFS_PERIPH_3, OFS_COMP_0,
         OFS_COMP_1,   OFS_COMP_2,   OFS_COMP_3:   m = 1'b1;
         default:                                  m = 1'b0;
      endcase
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Answer every request one cycle later
      st_nxt.rsp.valid  = bus_req_in.valid;
      st_nxt.rsp.decerr = bus_req_in.valid && bus_req_in.nonsecure;
      st_nxt.rsp.rdata  = ZERO_WORD;
      if (sec_ok && !bus_req_in.write) begin
         st_nxt.rsp.rdata = read_word(word_addr, st_r);
      end

      // Register writes; status itself takes none, aliases do the work
      if (wr_ok) begin
         case (word_addr)
            OFS_DBG_SET:  st_nxt.dbg  = st_r.dbg | dbg_wbits;
            OFS_DBG_CLR:  st_nxt.dbg  = st_r.dbg & ~dbg_wbits;
            OFS_AUX_DBG:  st_nxt.aux  = bus_req_in.wdata[AUX_W-1:0];
            OFS_WDOG_HOD: st_nxt.wdog = bus_req_in.wdata[WDOG_W-1:0];
            OFS_GP_STORE: st_nxt.gp   = bus_req_in.wdata[GP_W-1:0];
            default:      st_nxt.dbg  = st_r.dbg;
         endcase
      end

      // Source selection for the secure and device authentication enables
      st_nxt.en.sec_inv    = st_r.dbg[IX_SIV_SEL] ? st_r.dbg[IX_SIV_INT]
                                                  : secure_invasive_cfg_input_in;
      st_nxt.en.sec_noninv = st_r.dbg[IX_SNI_SEL] ? st_r.dbg[IX_SNI_INT]
                                                  : secure_noninvasive_cfg_input_in;
      st_nxt.en.device     = st_r.dbg[IX_DEV_SEL] ? st_r.dbg[IX_DEV_INT]
                                                  : device_dbg_cfg_input_in;
      // Non-secure self-hosted debug override
      st_nxt.en.inv        = (st_r.aux == AUX_ALL_EN);
      st_nxt.en.noninv     = (st_r.aux == AUX_ALL_EN) ||
                             (st_r.aux == AUX_NONINV);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // resetn_in is the always-on power-up reset: nothing else clears
   // this state, so lower domains powering down leave it intact.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r.dbg    <= DBG_RST;
         st_r.aux    <= AUX_RST;
         st_r.wdog   <= WDOG_RST;
         st_r.gp     <= GP_RST;
         st_r.rsp    <= '0;
         st_r.en     <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ---------------------------------------------------------------
   assign bus_rsp_out                      = st_r.rsp;
   assign secure_invasive_dbg_en_out       = st_r.en.sec_inv;
   assign secure_noninvasive_dbg_en_out    = st_r.en.sec_noninv;
   assign device_dbg_en_out                = st_r.en.device;
   assign invasive_dbg_en_out              = st_r.en.inv;
   assign noninvasive_dbg_en_out           = st_r.en.noninv;
   assign control_cpu_wdog_halt_enable_out = st_r.wdog[IX_CPU_WDOG];
   assign trusted_wdog_halt_enable_out     = st_r.wdog[IX_TRUST_WDOG];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   AST_NONSEC_DECERR: assert property (
      bus_req_in.valid && bus_req_in.nonsecure
      |=> bus_rsp_out.valid && bus_rsp_out.decerr &&
          bus_rsp_out.rdata == ZERO_WORD)
      else $error("non-secure access not answered with decode error");

   AST_UNIMPL_RAZ: assert property (
      sec_ok && !bus_req_in.write && !is_mapped(word_addr)
      |=> bus_rsp_out.valid && !bus_rsp_out.decerr &&
          bus_rsp_out.rdata == ZERO_WORD)
      else $error("unimplemented secure read not zero");

   AST_IC_ZERO: assert property (
      sec_ok && !bus_req_in.write && word_addr <= OFS_IC_CLR
      |=> bus_rsp_out.rdata == ZERO_WORD)
      else $error("interconnect word read not zero");

   AST_SIV_MUX: assert property (
      ##1 secure_invasive_dbg_en_out ==
          ($past(st_r.dbg[IX_SIV_SEL]) ? $past(st_r.dbg[IX_SIV_INT])
                                      : $past(secure_invasive_cfg_input_in)))
      else $error("secure invasive enable source wrong");

   AST_SNI_MUX: assert property (
      st_r.dbg[IX_SNI_SEL] && st_r.dbg[IX_SNI_INT] ##1 st_r.dbg[IX_SNI_SEL]
      |-> secure_noninvasive_dbg_en_out)
      else $error("secure non-invasive enable not from internal bit");

   AST_DEV_MUX: assert property (
      !st_r.dbg[IX_DEV_SEL]
      |=> device_dbg_en_out == $past(device_dbg_cfg_input_in))
      else $error("device enable not following external input");

   AST_STAT_RO: assert property (
      wr_ok && word_addr == OFS_DBG_STAT |=> $stable(st_r.dbg))
      else $error("status register accepted a write");

   AST_SET_ALIAS: assert property (
      wr_ok && word_addr == OFS_DBG_SET
      |=> st_r.dbg == ($past(st_r.dbg) | $past(dbg_wbits)))
      else $error("set alias result wrong");

   AST_CLR_ALIAS: assert property (
      wr_ok && word_addr == OFS_DBG_CLR
      |=> st_r.dbg == ($past(st_r.dbg) & ~$past(dbg_wbits)))
      else $error("clear alias result wrong");

   AST_AUX_OVERRIDE: assert property (
      st_r.aux == AUX_NONINV
      |=> !invasive_dbg_en_out && noninvasive_dbg_en_out)
      else $error("override 01 does not split enables");

   AST_WDOG_WRITE: assert property (
      wr_ok && word_addr == OFS_WDOG_HOD
      |=> control_cpu_wdog_halt_enable_out == $past(bus_req_in.wdata[1]) &&
          trusted_wdog_halt_enable_out == $past(bus_req_in.wdata[0]))
      else $error("watchdog halt enables not written");

   AST_GP_UPPER: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_GP_STORE
      |=> bus_rsp_out.rdata[31:16] == 16'h0000 &&
          bus_rsp_out.rdata[15:0] == st_r.gp)
      else $error("storage read back wrong");

   AST_NONSEC_NOWRITE: assert property (
      bus_req_in.valid && bus_req_in.nonsecure
      |=> $stable(st_r.dbg) && $stable(st_r.aux) &&
          $stable(st_r.wdog) && $stable(st_r.gp))
      else $error("non-secure access changed state");

   AST_COMP_ID: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_COMP_3
      |=> bus_rsp_out.rdata == COMP_3_VAL)
      else $error("component identity wrong");

   AST_UNIMPL_WI: assert property (
      wr_ok && !is_mapped(word_addr)
      |=> $stable(st_r.dbg) && $stable(st_r.aux) &&
          $stable(st_r.wdog) && $stable(st_r.gp))
      else $error("write to a hole changed state");

   AST_SECURE_OKAY: assert property (
      sec_ok |=> bus_rsp_out.valid && !bus_rsp_out.decerr)
      else $error("secure access answered with an error");

   AST_STAT_READ: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_DBG_STAT
      |=> bus_rsp_out.rdata == (32'($past(st_r.dbg)) << DBG_LSB))
      else $error("status read back wrong");

   AST_ALIAS_RAZ: assert property (
      sec_ok && !bus_req_in.write &&
      (word_addr == OFS_DBG_SET || word_addr == OFS_DBG_CLR)
      |=> bus_rsp_out.rdata == ZERO_WORD)
      else $error("alias word did not read zero");

   AST_AUX_WRITE: assert property (
      wr_ok && word_addr == OFS_AUX_DBG
      |=> st_r.aux == $past(bus_req_in.wdata[AUX_W-1:0]))
      else $error("auxiliary word not written");

   AST_AUX_ALL_ON: assert property (
      st_r.aux == AUX_ALL_EN
      |=> invasive_dbg_en_out && noninvasive_dbg_en_out)
      else $error("override 00 does not enable both");

   AST_AUX_ALL_OFF: assert property (
      st_r.aux != AUX_ALL_EN && st_r.aux != AUX_NONINV
      |=> !invasive_dbg_en_out && !noninvasive_dbg_en_out)
      else $error("override 1x does not disable both");

   AST_WDOG_READ: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_WDOG_HOD
      |=> bus_rsp_out.rdata == 32'($past(st_r.wdog)))
      else $error("watchdog word read back wrong");

   AST_GP_WRITE: assert property (
      wr_ok && word_addr == OFS_GP_STORE
      |=> st_r.gp == $past(bus_req_in.wdata[GP_W-1:0]))
      else $error("storage word not written");

   AST_VERSION_RO: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_VERSION
      |=> bus_rsp_out.rdata == VERSION_VAL)
      else $error("version word wrong");

   AST_PERIPH_ZERO: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_PERIPH_3
      |=> bus_rsp_out.rdata == PERIPH_3_VAL)
      else $error("last peripheral identity word not zero");

   AST_COMPONENT_ID_0: assert property (
      sec_ok && !bus_req_in.write && word_addr == OFS_COMP_0
      |=> bus_rsp_out.rdata == COMP_0_VAL)
      else $error("first component identity word wrong");

   AST_RSP_PULSE: assert property (
      !bus_req_in.valid
      |=> !bus_rsp_out.valid && !bus_rsp_out.decerr &&
          bus_rsp_out.rdata == ZERO_WORD)
      else $error("answer without a request");

   // Main scenarios
   COV_SET_THEN_INTERNAL: cover property (
      wr_ok && word_addr == OFS_DBG_SET ##2 secure_invasive_dbg_en_out);
   COV_NONSEC_REJECT: cover property (
      bus_req_in.valid && bus_req_in.nonsecure && bus_req_in.write);
   COV_AUX_SPLIT: cover property (
      !invasive_dbg_en_out && noninvasive_dbg_en_out);
   COV_GP_WRITE: cover property (
      wr_ok && word_addr == OFS_GP_STORE);
   COV_HOLE_READ: cover property (
      sec_ok && !bus_req_in.write && !is_mapped(word_addr));

endmodule

// >>> test/sdac_bus_master.sv
// Bus master model, secure or non-secure per request, facing the register bank request port
`timescale 1ns/100ps

module sdac_bus_master (
   input  wire logic                sys_clk_in,
   input  wire sdac_pkg::sdac_rsp_t bus_rsp_in,
   output      sdac_pkg::sdac_req_t bus_req_out
);
   import sdac_pkg::*;

   // Quiet port until the first request
   initial bus_req_out = '0;

   // One request, driven just after an edge and held up to the taking edge
   task automatic access(input logic wr, input logic ns,
                         input logic [11:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata, output logic decerr,
                         output logic seen);
      @(posedge sys_clk_in);
      #1;
      bus_req_out = '{valid: 1'b1, write: wr, nonsecure: ns, addr: addr,
                      wdata: wdata};
      @(posedge sys_clk_in);
      #1;
      seen = bus_rsp_in.valid;
      rdata = bus_rsp_in.rdata;
      decerr = bus_rsp_in.decerr;
      // Released lines carry the inverse so stale values never look valid
      bus_req_out = '{valid: 1'b0, write: ~wr, nonsecure: ~ns, addr: ~addr,
                      wdata: ~wdata};
   endtask
endmodule

// >>> test/test_sdac_bank.sv
// Self-checking testbench for the security debug authentication bank
`timescale 1ns/100ps

module test_sdac_bank;
   import sdac_pkg::*;

   // ---------------------------------------------------------------
   // Identity values for the instance (arbitrary values)
   // ---------------------------------------------------------------
   localparam logic [31:0] VER_V = 32'h0000_0021;
   localparam logic [31:0] P4_V  = 32'h0000_0022;
   localparam logic [31:0] P0_V  = 32'h0000_0023;
   localparam logic [31:0] P1_V  = 32'h0000_0024;
   localparam logic [31:0] P2_V  = 32'h0000_0025;

   logic        sys_clk_in;
   logic        resetn_in;
   logic [2:0]  cfg;
   sdac_req_t   req;
   sdac_rsp_t   rsp;
   logic [6:0]  en;
   logic [31:0] seed;
   logic [31:0] r;
   logic [31:0] d;
   logic [11:0] a;
   int          bad_count;
   int          tests_run;
   int          m_dbg, m_aux, m_wdog, m_gp;
   logic [11:0] ofs_tab [20] = '{OFS_IC_STAT, OFS_IC_SET, OFS_IC_CLR,
      OFS_DBG_STAT, OFS_DBG_SET, OFS_DBG_CLR, OFS_AUX_DBG, OFS_WDOG_HOD,
      OFS_GP_STORE, OFS_VERSION, OFS_PERIPH_4, OFS_PERIPH_0, OFS_PERIPH_1,
      OFS_PERIPH_2, OFS_PERIPH_3, OFS_COMP_0, OFS_COMP_1, OFS_COMP_2,
      OFS_COMP_3, 12'h020};

   sdac_bank #(
      .VERSION_VAL  (VER_V),
      .PERIPH_4_VAL (P4_V),
      .PERIPH_0_VAL (P0_V),
      .PERIPH_1_VAL (P1_V),
      .PERIPH_2_VAL (P2_V)
   ) dut_u (
      .sys_clk_in                       (sys_clk_in),
      .resetn_in                        (resetn_in),
      .bus_req_in                       (req),
      .bus_rsp_out                      (rsp),
      .secure_invasive_cfg_input_in     (cfg[2]),
      .secure_noninvasive_cfg_input_in  (cfg[1]),
      .device_dbg_cfg_input_in          (cfg[0]),
      .secure_invasive_dbg_en_out       (en[6]),
      .secure_noninvasive_dbg_en_out    (en[5]),
      .device_dbg_en_out                (en[4]),
      .invasive_dbg_en_out              (en[3]),
      .noninvasive_dbg_en_out           (en[2]),
      .control_cpu_wdog_halt_enable_out (en[1]),
      .trusted_wdog_halt_enable_out     (en[0])
   );

   sdac_bus_master master_u (
      .sys_clk_in  (sys_clk_in),
      .bus_rsp_in  (rsp),
      .bus_req_out (req)
   );

   // ---------------------------------------------------------------
   // Clock, random source, compare and verdict
   // ---------------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Reference model; the low two address bits are ignored
   // ---------------------------------------------------------------
   function automatic logic [31:0] exp_rd(input logic [11:0] ad);
      case ({ad[11:2], 2'b00})
         OFS_DBG_STAT: return 32'(m_dbg) << 2;
         OFS_AUX_DBG:  return 32'(m_aux);
         OFS_WDOG_HOD: return 32'(m_wdog);
         OFS_GP_STORE: return 32'(m_gp);
         OFS_VERSION:  return VER_V;
         OFS_PERIPH_4: return P4_V;
         OFS_PERIPH_0: return P0_V;
         OFS_PERIPH_1: return P1_V;
         OFS_PERIPH_2: return P2_V;
         OFS_COMP_0:   return 32'h0000_000d;
         OFS_COMP_1:   return 32'h0000_00f0;
         OFS_COMP_2:   return 32'h0000_0005;
         OFS_COMP_3:   return 32'h0000_00b1;
         default:      return 32'h0000_0000;
      endcase
   endfunction

   // Status moves only through the alias words; its own offset is dropped
   task automatic model_wr(input logic [11:0] ad, input logic [31:0] wd);
      case ({ad[11:2], 2'b00})
         OFS_DBG_SET:  m_dbg = m_dbg | int'(wd[7:2]);
         OFS_DBG_CLR:  m_dbg = m_dbg & ~int'(wd[7:2]);
         OFS_AUX_DBG:  m_aux = int'(wd[1:0]);
         OFS_WDOG_HOD: m_wdog = int'(wd[1:0]);
         OFS_GP_STORE: m_gp = int'(wd[15:0]);
         default: ;
      endcase
   endtask

   // One access, then the idle response and the settled enables
   task automatic op(input logic wr, input logic ns, input logic [11:0] ad,
                     input logic [31:0] wd);
      logic [31:0] rd;
      logic        de;
      logic        seen;
      logic [6:0]  e;
      master_u.access(wr, ns, ad, wd, rd, de, seen);
      if (!ns && wr) model_wr(ad, wd);
      chk("rsp_valid", 32'h1, {31'h0, seen});
      chk("decerr", {31'h0, ns}, {31'h0, de});
      chk("rdata", (ns || wr) ? 32'h0 : exp_rd(ad), rd);
      e = {m_dbg[5] ? m_dbg[4] : cfg[2], m_dbg[3] ? m_dbg[2] : cfg[1],
           m_dbg[1] ? m_dbg[0] : cfg[0], m_aux == 0, m_aux < 2,
           m_wdog[1], m_wdog[0]};
      @(posedge sys_clk_in);
      #1;
      chk("rsp_idle", 32'h0, {31'h0, rsp.valid});
      @(posedge sys_clk_in);
      #1;
      chk("enables", {25'h0, e}, {25'h0, en});
   endtask

   // ---------------------------------------------------------------
   // Main sequence: two runs, each opened by a full reset
   // ---------------------------------------------------------------
   initial begin
      resetn_in = 1'b0;
      cfg = 3'h0;
      seed = 32'd66022;
      bad_count = 0;
      tests_run = 0;
      for (int pass = 0; pass < 2; pass++) begin
         m_dbg = 0; m_aux = 0; m_wdog = 0; m_gp = 0;
         resetn_in = 1'b0;
         repeat (4) @(posedge sys_clk_in);
         #1;
         resetn_in = 1'b1;
         // Retained word must come back zero after the second reset too
         foreach (ofs_tab[i]) op(1'b0, 1'b0, ofs_tab[i], 32'h0);
         for (int v = 0; v < 4; v++) op(1'b1, 1'b0, OFS_AUX_DBG, v);
         for (int k = 0; k < 400; k++) begin
            r = xs();
            d = xs();
            cfg = r[2:0];
            a = r[3] ? (ofs_tab[r[8:4] % 20] | {10'h0, r[10:9]}) : r[22:11];
            op(r[23], r[26:24] == 3'h0, a, d);
         end
      end
      final_report();
   end

   // Run needs about 3400 cycles; cut a hang well beyond that
   initial begin
      #2_000_000;
      bad_count = bad_count + 1;
      final_report();
   end
endmodule
